// >>> core/uml_defines.svh
// How it works
// - Writing one to control bit 4 enters internal loopback diagnostic mode.
// - In loopback the serial output pin is held at mark, logic one.
// - In loopback the external serial input pin is ignored by the receiver.
// - In loopback the transmit shift output feeds the receive shift input.
// - In loopback the four external modem status inputs are disconnected.
// - In loopback both modem control output pins are forced high, inactive.
// - Receive and transmit interrupts keep working in loopback mode.
// - In loopback modem status comes from control bits 3..0, still interrupt-gated.
// - Outside loopback, control bit 1 drives request-to-send low when set; bit 0 terminal-ready likewise.
`ifndef UML_DEFINES_SVH
`define UML_DEFINES_SVH
`define UML_OFS_MCTRL    12'h010
`define UML_OFS_ISTAT    12'h020
`define UML_OFS_IMASK    12'h024
`define UML_OFS_MSTAT    12'h028
`define UML_BIT_DTR      0
`define UML_BIT_RTS      1
`define UML_BIT_OUT1     2
`define UML_BIT_OUT2     3
`define UML_BIT_LOOP     4
`define UML_MCTRL_MASK   8'h1f
`define UML_MCTRL_RESET  8'h00
`define UML_IRQ_W        3
`define UML_IRQ_RX       0
`define UML_IRQ_TX       1
`define UML_IRQ_MODEM    2
`endif

// >>> core/uml_pkg.sv
package uml_pkg;
    typedef logic [7:0]  uml_byte_t;
    typedef logic [3:0]  uml_modem_t;
    typedef enum logic [1:0] {
        UML_APB_IDLE   = 2'b00,
        UML_APB_ACCESS = 2'b01
    } uml_apb_e;
    typedef struct packed {
        logic [2:0] sync0;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic       value;
    } uml_sync_s;
    typedef struct packed {
        uml_modem_t ff1;
        uml_modem_t ff2;
        uml_modem_t ff3;
        uml_modem_t value;
    } uml_msync_s;
endpackage

// >>> core/uml_pin_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; level accepted once stages two and three agree
module uml_pin_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // Pin and result
    input  wire logic pin,
    output logic      level
);
    import uml_pkg::*;
    logic [2:0] chain;
    logic       next_level;
    always_comb begin
        next_level = (chain[1] == chain[2]) ? chain[2] : level;
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            chain <= 3'h7;
            level <= 1'b1;
        end else begin
            chain <= {chain[1:0], pin};
            level <= next_level;
        end
    end
endmodule

// >>> core/uml_modem_sync.sv
`timescale 1ns/1ps
// Four modem status pins, each through a three-stage synchroniser
module uml_modem_sync (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    // Pins, active low, and synchronised levels
    input  wire uml_pkg::uml_modem_t pins_n,
    output uml_pkg::uml_modem_t      levels_n
);
    import uml_pkg::*;
    uml_msync_s st;
    uml_msync_s next_st;
    always_comb begin
        next_st       = st;
        next_st.ff1   = pins_n;
        next_st.ff2   = st.ff1;
        next_st.ff3   = st.ff2;
        for (int i = 0; i < 4; i++) begin
            if (st.ff2[i] == st.ff3[i]) begin
                next_st.value[i] = st.ff3[i];
            end
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= {16{1'b1}};
        end else begin
            st <= next_st;
        end
    end
    assign levels_n = st.value;
endmodule

// >>> core/uml_modem_loop.sv
`timescale 1ns/1ps
`include "uml_defines.svh"
module uml_modem_loop (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial pins
    input  wire logic        serial_rx_pin,
    output logic             serial_tx_pin,
    // Modem pins, active low
    input  wire logic        clear_to_send_in_n,
    input  wire logic        data_set_ready_in_n,
    input  wire logic        carrier_detect_in_n,
    input  wire logic        ring_indicator_in_n,
    output logic             terminal_ready_out_n,
    output logic             request_send_out_n,
    // Core-side serial paths
    input  wire logic        tx_shift_out,
    output logic             rx_shift_in,
    // Core interrupt events
    input  wire logic        rx_event,
    input  wire logic        tx_event,
    // Modem status to core, active high: cts, dsr, ri, dcd
    output uml_pkg::uml_modem_t modem_status,
    output logic             irq
);
    import uml_pkg::*;

    typedef struct packed {
        uml_byte_t              mctrl;
        logic [`UML_IRQ_W-1:0]  istat;
        logic [`UML_IRQ_W-1:0]  imask;
        uml_modem_t             mstat;
        uml_apb_e               bus;
        logic [31:0]            rdata;
        logic                   ready;
        logic                   slverr;
        logic                   tx_pin;
        logic                   rx_in;
        logic                   dtr_n;
        logic                   rts_n;
        logic                   irq;
    } uml_state_s;

    uml_state_s st;
    uml_state_s next_st;
    logic       rx_pin_s;
    uml_modem_t ext_n;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    uml_pin_sync u_rx_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin     (serial_rx_pin),
        .level   (rx_pin_s)
    );

    uml_modem_sync u_modem_sync (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .pins_n   ({carrier_detect_in_n, ring_indicator_in_n,
                    data_set_ready_in_n, clear_to_send_in_n}),
        .levels_n (ext_n)
    );

    always_comb begin
        logic       loop;
        uml_modem_t src;
        logic [`UML_IRQ_W-1:0] ev;
        logic       rd;
        logic       wr;
        next_st = st;
        loop    = st.mctrl[`UML_BIT_LOOP];
        rd      = 1'b0;
        wr      = 1'b0;
        src     = '0;
        ev      = '0;
        // Modem status: internal control bits in loopback
        if (loop) begin
            // cts<-rts, dsr<-dtr, ri<-out1, dcd<-out2
            src = {st.mctrl[`UML_BIT_OUT2], st.mctrl[`UML_BIT_OUT1],
                   st.mctrl[`UML_BIT_DTR], st.mctrl[`UML_BIT_RTS]};
        end else begin
            src = ~ext_n;
        end
        next_st.mstat = src;
        ev[`UML_IRQ_RX]    = rx_event;
        ev[`UML_IRQ_TX]    = tx_event;
        ev[`UML_IRQ_MODEM] = (src != st.mstat);
        // APB
        next_st.ready  = 1'b0;
        next_st.slverr = 1'b0;
        case (st.bus)
            UML_APB_IDLE: begin
                if (psel && !penable) begin
                    next_st.bus = UML_APB_ACCESS;
                end
            end
            UML_APB_ACCESS: begin
                if (psel && penable && !st.ready) begin
                    next_st.ready = 1'b1;
                    next_st.rdata = 32'h0;
                    if (pwrite) begin
                        wr = 1'b1;
                    end else begin
                        rd = 1'b1;
                    end
                    if (hit(paddr, `UML_OFS_MCTRL)) begin
                        next_st.rdata = {24'h0, st.mctrl};
                    end else if (hit(paddr, `UML_OFS_ISTAT)) begin
                        next_st.rdata = {29'h0, st.istat};
                    end else if (hit(paddr, `UML_OFS_IMASK)) begin
                        next_st.rdata = {29'h0, st.imask};
                    end else if (hit(paddr, `UML_OFS_MSTAT)) begin
                        next_st.rdata = {28'h0, st.mstat};
                    end else begin
                        next_st.slverr = 1'b1;
                    end
                end else if (st.ready) begin
                    next_st.bus = (psel && !penable) ? UML_APB_ACCESS : UML_APB_IDLE;
                end
            end
            default: begin
                next_st.bus = UML_APB_IDLE;
            end
        endcase
        if (wr && hit(paddr, `UML_OFS_MCTRL)) begin
            next_st.mctrl = pwdata[7:0] & `UML_MCTRL_MASK;
        end
        if (wr && hit(paddr, `UML_OFS_IMASK)) begin
            next_st.imask = pwdata[`UML_IRQ_W-1:0];
        end
        // Read clears; a same-cycle event survives
        if (rd && hit(paddr, `UML_OFS_ISTAT)) begin
            next_st.istat = ev;
        end else begin
            next_st.istat = st.istat | ev;
        end
        next_st.irq = |(next_st.istat & next_st.imask);
        // Pins, from the next control value
        if (next_st.mctrl[`UML_BIT_LOOP]) begin
            next_st.tx_pin = 1'b1;
            next_st.rx_in  = tx_shift_out;
            next_st.dtr_n  = 1'b1;
            next_st.rts_n  = 1'b1;
        end else begin
            next_st.tx_pin = tx_shift_out;
            next_st.rx_in  = rx_pin_s;
            next_st.dtr_n  = ~next_st.mctrl[`UML_BIT_DTR];
            next_st.rts_n  = ~next_st.mctrl[`UML_BIT_RTS];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st        <= '0;
            st.mctrl  <= `UML_MCTRL_RESET;
            st.bus    <= UML_APB_IDLE;
            st.tx_pin <= 1'b1;
            st.rx_in  <= 1'b1;
            st.dtr_n  <= 1'b1;
            st.rts_n  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata               = st.rdata;
    assign pready               = st.ready;
    assign pslverr              = st.slverr;
    assign serial_tx_pin        = st.tx_pin;
    assign rx_shift_in          = st.rx_in;
    assign terminal_ready_out_n = st.dtr_n;
    assign request_send_out_n   = st.rts_n;
    assign modem_status         = st.mstat;
    assign irq                  = st.irq;
endmodule

// >>> verification/uml_modem_loop_monitor.sv
`timescale 1ns/1ps
module uml_modem_loop_monitor (
    // Clock, reset and bus
    input wire logic                sys_clk,
    input wire logic                arst_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    // Pins and core side
    input wire logic                serial_tx_pin,
    input wire logic                tx_shift_out,
    input wire logic                rx_shift_in,
    input wire logic                terminal_ready_out_n,
    input wire logic                request_send_out_n,
    input wire uml_pkg::uml_modem_t modem_status,
    input wire logic                irq
);
    import uml_pkg::*;
    logic [4:0] ctrl_q;
    logic [4:0] cur;
    logic [2:0] mask;
    logic       wr;
    // Control value as the pins see it, new value in its completing cycle
    assign wr  = psel && penable && pready && pwrite;
    assign cur = (wr && paddr == 12'h010) ? pwdata[4:0] : ctrl_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= 5'h00;
            mask   <= 3'h0;
        end else begin
            ctrl_q <= cur;
            if (wr && paddr == 12'h024) mask <= pwdata[2:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_loop_held;
        (cur[4] && $stable(cur)) [*6];
    endsequence
    property p_tx_mark; cur[4] |-> serial_tx_pin; endproperty
    a_tx_mark: assert property (p_tx_mark) else $error("tx not mark");
    property p_tx_pass; !cur[4] |-> serial_tx_pin == $past(tx_shift_out); endproperty
    a_tx_pass: assert property (p_tx_pass) else $error("tx path wrong");
    property p_rx_loop; cur[4] && $past(cur[4]) |-> rx_shift_in == $past(tx_shift_out); endproperty
    a_rx_loop: assert property (p_rx_loop) else $error("rx not looped");
    property p_ctl_out;
        request_send_out_n == (cur[4] | !cur[1]) && terminal_ready_out_n == (cur[4] | !cur[0]);
    endproperty
    a_ctl_out: assert property (p_ctl_out) else $error("control pins wrong");
    property p_mstat_loop;
        s_loop_held |-> modem_status == {cur[3], cur[2], cur[0], cur[1]};
    endproperty
    a_mstat_loop: assert property (p_mstat_loop) else $error("loop status wrong");
    property p_ready; s_access |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("bad ready timing");
    property p_ctrl_read;
        psel && penable && pready && !pwrite && paddr == 12'h010 |-> prdata == {27'h0, ctrl_q};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback");
    property p_irq_modem;
        cur[4] && $past(cur[4]) && $changed(cur[3:0]) && mask[2] |-> ##[1:8] irq;
    endproperty
    a_irq_modem: assert property (p_irq_modem) else $error("no modem irq");
endmodule
bind uml_modem_loop uml_modem_loop_monitor uml_modem_loop_monitor_i (.*);

// >>> verification/uml_modem_partner.sv
`timescale 1ns/1ps
// Data set: answers the handshake lines, bench sets rx and dcd/ri levels
module uml_modem_partner (
    input  wire logic [2:0] line,
    input  wire logic       terminal_ready_out_n,
    input  wire logic       request_send_out_n,
    output logic            serial_rx_pin,
    output logic            clear_to_send_in_n,
    output logic            data_set_ready_in_n,
    output logic            carrier_detect_in_n,
    output logic            ring_indicator_in_n
);
    assign clear_to_send_in_n  = request_send_out_n;
    assign data_set_ready_in_n = terminal_ready_out_n;
    assign {serial_rx_pin, carrier_detect_in_n, ring_indicator_in_n} = line;
endmodule

// >>> verification/test_uml_modem_loop.sv
`timescale 1ns/1ps
module test_uml_modem_loop;
    import uml_pkg::*;
    logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, err, prev, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic        serial_rx_pin, serial_tx_pin, tx_shift_out, rx_shift_in, rx_event, tx_event;
    logic        clear_to_send_in_n, data_set_ready_in_n, carrier_detect_in_n;
    logic        ring_indicator_in_n, terminal_ready_out_n, request_send_out_n;
    logic [2:0]  line;
    logic [3:0]  ms;
    uml_modem_t  modem_status;
    int          miscompares, tests_run, ctrl, n;
    uml_modem_loop    uml_modem_loop_i (.*);
    uml_modem_partner uml_modem_partner_i (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic void rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            test_done();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stream(input int cyc);
        repeat (cyc) begin
            @(posedge sys_clk);
            rnd();
            prev = tx_shift_out;
            tx_shift_out <= seed[0];
            line[2]      <= seed[1];
            @(negedge sys_clk);
            chk(serial_tx_pin, ctrl[4] ? 1'b1 : prev);
            if (ctrl[4]) chk(rx_shift_in, prev);
        end
    endtask
    task automatic wr_ctrl(input logic [7:0] v);
        ctrl = v & 8'h1f;
        apb(1'b1, 12'h010, {24'h0, v});
        repeat (8) @(posedge sys_clk);
        ms = ctrl[4] ? {ctrl[3], ctrl[2], ctrl[0], ctrl[1]}
                     : {~line[1], ~line[0], ctrl[0], ctrl[1]};
        chk({request_send_out_n, terminal_ready_out_n},
            ctrl[4] ? 2'b11 : {~ctrl[1], ~ctrl[0]});
        chk(modem_status, ms);
        chk(rx_shift_in, ctrl[4] ? tx_shift_out : line[2]);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, ctrl);
        apb(1'b0, 12'h028, 32'h0);
        chk(rd, {28'h0, ms});
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rx_event, tx_event, arst_n} = '0;
        {tx_shift_out, line, seed, ctrl} = {4'hf, 32'h51, 32'h0};
        repeat (8) @(posedge sys_clk);
        chk({serial_tx_pin, request_send_out_n, terminal_ready_out_n}, 3'b111);
        chk({pready, irq, modem_status, rx_shift_in}, 7'h01);
        chk(prdata, 32'h0);
        arst_n <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        for (int i = 0; i < 60; i++) begin
            rnd();
            line[1:0] <= seed[5:4];
            wr_ctrl(seed[31:24]);
            stream(6);
            rnd();
            apb(1'b1, 12'h024, {29'h0, seed[10:8]});
            apb(1'b0, 12'h020, 32'h0);
            @(posedge sys_clk);
            rx_event <= seed[12];
            tx_event <= seed[13];
            @(posedge sys_clk);
            rx_event <= 1'b0;
            tx_event <= 1'b0;
            repeat (3) @(posedge sys_clk);
            chk(irq, |(seed[13:12] & seed[9:8]));
            apb(1'b0, 12'h020, 32'h0);
            chk(rd, {30'h0, seed[13:12]});
        end
        test_done();
    end
endmodule
